/* File: logic/baud_tick_gen.v */
// baud tick generator: one tick per bit period (clock / (32 * divisor))
`timescale 1ns/1ps
module baud_tick_gen #(
    parameter DIV_W = 13,
    parameter OVS   = 32
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_b_i,
    // divisor and tick
    input  wire [DIV_W-1:0] divisor_i,
    output reg              tick_o
);
    reg [DIV_W-1:0] pre_q;
    reg [4:0]       ovs_q;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q  <= {DIV_W{1'b0}};
            ovs_q  <= 5'h00;
            tick_o <= 1'b0;
        end else if (divisor_i == {DIV_W{1'b0}}) begin
            // zero divisor halts the generator outright
            pre_q  <= {DIV_W{1'b0}};
            ovs_q  <= 5'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (pre_q >= divisor_i - 1'b1) begin
                pre_q <= {DIV_W{1'b0}};
                ovs_q <= ovs_q + 5'h01;
                if (ovs_q == OVS[4:0] - 5'h01) begin
                    tick_o <= 1'b1;
                end
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end
endmodule

/* File: logic/serial_cfg_map.vh */
// register offsets, field positions and reset values of the serial configuration block
`ifndef SERIAL_CFG_MAP_VH
`define SERIAL_CFG_MAP_VH
`define ADDR_BAUD        4'h0
`define ADDR_CTRL        4'h1
`define ADDR_TXDATA      4'h2
`define ADDR_RXDATA      4'h3
`define ADDR_STATUS      4'h4
`define ADDR_IRQ_STAT    4'h5
`define ADDR_IRQ_MASK    4'h6
`define CTRL_RESET       16'h0000
`define CTRL_WMASK       16'h7FFF
`define BIT_LOOP         14
`define BIT_OPEN_DRAIN   13
`define BIT_IDLE_KIND    12
`define BIT_PAR_ODD      11
`define BIT_PAR_ON       10
`define BIT_NINE         9
`define BIT_WAKE_ADDR    8
`define BIT_TX_ON        3
`define BIT_RX_ON        2
`define BIT_RX_WAKEUP    1
`define BIT_BREAK        0
`define EV_TX_EMPTY      0
`define EV_TX_DONE       1
`define EV_RX_FULL       2
`define EV_IDLE          3
`define OVERSAMPLE       32
`define HALF_SAMPLE      16
`endif

/* File: logic/serial_cfg_top.v */
// serial port: baud divisor, control register, transmitter, receiver, interrupts
// Functional notes
// - bit rate is system clock divided by 32 times the 13-bit divisor
// - a zero divisor stops the baud generator completely
// - loopback bit feeds transmitter output back into the receiver
// - open-drain bit makes transmit pin drive low only
// - idle count starts on first one, or after stop bit when set
// - parity only when enabled; even when type bit clear, odd when set
// - control holds frame, wake, irq enables, tx/rx enable, wakeup, break; reset clears
// - hardware may change the receiver wakeup bit on receive conditions
// - control bit 15 reads zero and ignores writes
`timescale 1ns/1ps
`include "serial_cfg_map.vh"
module serial_cfg_top #(
    parameter DIV_W = 13
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_b_i,
    // register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // serial line
    input  wire        rxd_i,
    output reg         txd_o,
    output reg         txd_oe_o,
    // interrupt
    output reg         irq_o
);
    ////////////////////////////////////////////////////////////////////////
    reg [DIV_W-1:0] baud_q;
    reg [15:0]      ctrl_q;
    reg [3:0]       irq_stat_q;
    reg [3:0]       irq_mask_q;
    reg [8:0]       txbuf_q;
    reg             txbuf_full_q;
    reg [10:0]      tsh_q;
    reg [3:0]       tcnt_q;
    reg             tbusy_q;
    reg             tx_line_q;
    reg [7:0]       rxbuf_q;
    reg             rx_full_q;
    reg             rx_perr_q;
    wire            tick;
    wire [7:0]      rx_data;
    wire            rx_done;
    wire            rx_perr;
    wire            rx_idle;

    function par_bit;
        input [8:0] d;
        input       nine;
        input       odd;
        begin
            par_bit = (^d[7:0]) ^ (nine & d[8]) ^ odd;
        end
    endfunction

    baud_tick_gen #(.DIV_W(DIV_W), .OVS(`OVERSAMPLE)) u_baud (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .divisor_i (baud_q),
        .tick_o    (tick)
    );

    // internal loop path ignores the pin entirely
    wire rx_line = ctrl_q[`BIT_LOOP] ? tx_line_q : rxd_i;

    serial_rx u_rx (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .enable_i    (ctrl_q[`BIT_RX_ON]),
        .pre_i       (9'h000),
        .nine_i      (ctrl_q[`BIT_NINE]),
        .par_on_i    (ctrl_q[`BIT_PAR_ON]),
        .par_odd_i   (ctrl_q[`BIT_PAR_ODD]),
        .idle_kind_i (ctrl_q[`BIT_IDLE_KIND]),
        .line_i      (rx_line),
        .tick_i      (tick),
        .data_o      (rx_data),
        .done_o      (rx_done),
        .perr_o      (rx_perr),
        .idle_o      (rx_idle)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    wire [3:0] nbits = {3'h0, ctrl_q[`BIT_NINE]} + 4'd8;
    wire       start_tx = ctrl_q[`BIT_TX_ON] & txbuf_full_q & ~tbusy_q & tick;
    wire [10:0] frame = ctrl_q[`BIT_NINE] ?
        {1'b1, (ctrl_q[`BIT_PAR_ON] ? par_bit(txbuf_q, 1'b0, ctrl_q[`BIT_PAR_ODD]) : txbuf_q[8]),
         txbuf_q[7:0], 1'b0} :
        {2'b11, (ctrl_q[`BIT_PAR_ON] ? par_bit(txbuf_q & 9'h07F, 1'b0, ctrl_q[`BIT_PAR_ODD]) : txbuf_q[7]),
         txbuf_q[6:0], 1'b0};
    wire tx_write = wr_i & (addr_i == `ADDR_TXDATA);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tsh_q <= 11'h7FF; tcnt_q <= 4'h0; tbusy_q <= 1'b0;
            tx_line_q <= 1'b1; txbuf_q <= 9'h000; txbuf_full_q <= 1'b0;
        end else begin
            if (start_tx) begin
                // start, data lsb first, parity in top data slot, stop
                tsh_q <= frame; tcnt_q <= 4'h0; tbusy_q <= 1'b1;
                txbuf_full_q <= 1'b0;
            end else if (tbusy_q && tick) begin
                tx_line_q <= tsh_q[0];
                tsh_q <= {1'b1, tsh_q[10:1]};
                tcnt_q <= tcnt_q + 4'h1;
                if (tcnt_q == nbits + 4'd1) tbusy_q <= 1'b0;
            end else if (!tbusy_q && tick) begin
                tx_line_q <= ~ctrl_q[`BIT_BREAK];
            end
            if (tx_write) begin
                txbuf_q <= wdata_i[8:0];
                txbuf_full_q <= 1'b1;
            end
        end
    end
    wire tx_done_ev = tbusy_q & tick & (tcnt_q == nbits + 4'd1);

    // pin: open-drain releases instead of driving high
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            txd_o <= 1'b1; txd_oe_o <= 1'b0;
        end else begin
            txd_o <= tx_line_q;
            txd_oe_o <= ctrl_q[`BIT_TX_ON] & (~ctrl_q[`BIT_OPEN_DRAIN] | ~tx_line_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; software should not alter control during a frame
    wire [3:0] ev = {rx_idle, rx_done, tx_done_ev, start_tx};
    wire       addr_match = rx_done & ctrl_q[`BIT_WAKE_ADDR] & (rx_data[7] | ctrl_q[`BIT_NINE]);
    wire       idle_wake = rx_idle & ~ctrl_q[`BIT_WAKE_ADDR];

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            baud_q <= {DIV_W{1'b0}}; ctrl_q <= `CTRL_RESET;
            irq_stat_q <= 4'h0; irq_mask_q <= 4'h0;
            rxbuf_q <= 8'h00; rx_full_q <= 1'b0; rx_perr_q <= 1'b0;
        end else begin
            if (wr_i && addr_i == `ADDR_BAUD) baud_q <= wdata_i[DIV_W-1:0];
            if (wr_i && addr_i == `ADDR_CTRL) ctrl_q <= wdata_i & `CTRL_WMASK;
            // receiver wakes itself on idle or address frame
            if (ctrl_q[`BIT_RX_WAKEUP] && (addr_match || idle_wake)) ctrl_q[`BIT_RX_WAKEUP] <= 1'b0;
            if (wr_i && addr_i == `ADDR_IRQ_MASK) irq_mask_q <= wdata_i[3:0];
            // set wins over write-one-to-clear
            irq_stat_q <= (irq_stat_q & ~((wr_i && addr_i == `ADDR_IRQ_STAT) ? wdata_i[3:0] : 4'h0)) | ev;
            if (rx_done && !ctrl_q[`BIT_RX_WAKEUP]) begin
                rxbuf_q <= rx_data; rx_full_q <= 1'b1; rx_perr_q <= rx_perr;
            end else if (rd_i && addr_i == `ADDR_RXDATA) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000; irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q & {ctrl_q[4], ctrl_q[5], ctrl_q[6], ctrl_q[7]});
            rdata_o <= 16'h0000;
            if (rd_i) begin
                case (addr_i)
                    `ADDR_BAUD:     rdata_o <= {{(16-DIV_W){1'b0}}, baud_q};
                    `ADDR_CTRL:     rdata_o <= ctrl_q;
                    `ADDR_RXDATA:   rdata_o <= {8'h00, rxbuf_q};
                    `ADDR_STATUS:   rdata_o <= {11'h000, rx_perr_q, rx_full_q, tbusy_q, txbuf_full_q, ~txbuf_full_q};
                    `ADDR_IRQ_STAT: rdata_o <= {12'h000, irq_stat_q};
                    `ADDR_IRQ_MASK: rdata_o <= {12'h000, irq_mask_q};
                    default:        rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule

/* File: logic/serial_rx.v */
// receiver: start detect, one sample per bit tick, parity check, idle detect
`timescale 1ns/1ps
module serial_rx (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_b_i,
    // configuration
    input  wire       enable_i,
    input  wire [8:0] pre_i,
    input  wire       nine_i,
    input  wire       par_on_i,
    input  wire       par_odd_i,
    input  wire       idle_kind_i,
    // line and bit-period timing
    input  wire       line_i,
    input  wire       tick_i,
    // results
    output reg  [7:0] data_o,
    output reg        done_o,
    output reg        perr_o,
    output reg        idle_o
);
    reg [3:0] cnt_q;
    reg       busy_q;
    reg [8:0] sh_q;
    reg [3:0] idle_cnt_q;
    reg       idle_arm_q;
    reg       idle_seen_q;
    wire [3:0] nbits = {3'h0, nine_i} + 4'd8;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 4'h0; busy_q <= 1'b0; sh_q <= 9'h000;
            data_o <= 8'h00; done_o <= 1'b0; perr_o <= 1'b0; idle_o <= 1'b0;
            idle_cnt_q <= 4'h0; idle_arm_q <= 1'b0; idle_seen_q <= 1'b0;
        end else begin
            done_o <= 1'b0;
            idle_o <= 1'b0;
            if (!enable_i) begin
                busy_q <= 1'b0;
            end else if (tick_i) begin
                if (!busy_q) begin
                    if (!line_i) begin
                        busy_q <= 1'b1; cnt_q <= 4'h0; idle_seen_q <= 1'b0; idle_arm_q <= 1'b0;
                    end else if (!idle_kind_i || idle_arm_q) begin
                        // short kind counts from any one, long only after a stop bit
                        if (idle_cnt_q == nbits + 4'd1) begin
                            if (!idle_seen_q) idle_o <= 1'b1;
                            idle_seen_q <= 1'b1;
                        end else begin
                            idle_cnt_q <= idle_cnt_q + 4'h1;
                        end
                    end
                    if (!line_i) idle_cnt_q <= 4'h0;
                end else if (cnt_q == nbits) begin
                    busy_q <= 1'b0;
                    idle_arm_q <= 1'b1;
                    idle_cnt_q <= 4'h0;
                    // an eight-bit frame ends one slot higher in the shifter than a nine-bit one
                    data_o <= nine_i ? sh_q[7:0] : sh_q[8:1];
                    perr_o <= par_on_i & ((nine_i ? ^sh_q[8:0] : ^sh_q[8:1]) ^ par_odd_i);
                    done_o <= 1'b1;
                end else begin
                    sh_q <= {line_i, sh_q[8:1]};
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
    wire unused_pre = ^pre_i;
endmodule

/* File: tb/remote_serial_peer.sv */
// model of the remote serial device driving the receive line
`timescale 1ns/1ps
module remote_serial_peer (
    // clock
    input  wire clk_i,
    // line toward the block
    output reg  rxd_o
);
    initial rxd_o = 1'b1; // idles at one between frames
    ////////////////////////////////////////////////////////////
    task send(input [7:0] d, input integer div);
        reg [9:0] f;
        integer   i;
        begin
            f = {1'b1, d, 1'b0};
            for (i = 0; i < 320 * div; i = i + 1) begin
                @(posedge clk_i);
                rxd_o <= f[i / (32 * div)];
            end
        end
    endtask
endmodule

/* File: tb/serial_cfg_checker_asserts.sv */
// port checker for the serial configuration block
`timescale 1ns/1ps
module serial_cfg_checker #(
    parameter DIV_W = 13
) (
    // clock and reset
    input wire        clk_i,
    input wire        rst_b_i,
    // register port
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    // line and interrupt
    input wire        txd_o,
    input wire        txd_oe_o,
    input wire        irq_o
);
    reg  [15:0] ctrl_q;
    reg  [12:0] baud_q;
    reg  [3:0]  mask_q;
    reg  [2:0]  zero_q;
    reg  [19:0] low_q;
    // pulled up when not driven, as on the board
    wire        line = txd_oe_o ? txd_o : 1'b1;
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= 16'h0000;
            baud_q <= 13'h0000;
            mask_q <= 4'h0;
            zero_q <= 3'h0;
            low_q  <= 20'h00000;
        end else begin
            if (wr_i && addr_i == 4'h1)
                ctrl_q <= wdata_i & 16'h7FFF;
            if (wr_i && addr_i == 4'h0)
                baud_q <= wdata_i[12:0];
            if (wr_i && addr_i == 4'h6)
                mask_q <= wdata_i[3:0];
            // saturate so the stop check waits out the tick pipeline
            zero_q <= (baud_q != 13'h0000) ? 3'h0 : (zero_q == 3'h4) ? zero_q : zero_q + 3'h1;
            low_q  <= line ? 20'h00000 : low_q + 20'h00001;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data not idle");
    AST_UNMAPPED: assert property ($past(rd_i) && $past(addr_i) > 4'h6 |-> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    AST_CTRL_READ: assert property ($past(rd_i) && $past(addr_i) == 4'h1
        |-> (rdata_o & 16'hFFFD) == ($past(ctrl_q) & 16'hFFFD)) else $error("control read back wrong");
    AST_BAUD_READ: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |-> rdata_o[12:0] == $past(baud_q))
        else $error("divisor read back wrong");
    AST_OPEN_DRAIN: assert property (ctrl_q[13] && $past(ctrl_q[13]) && txd_oe_o |-> !txd_o)
        else $error("open drain drove high");
    AST_STOPPED: assert property (zero_q == 3'h4 |-> $stable(txd_o)) else $error("line moved with zero divisor");
    AST_BIT_MULTIPLE: assert property ($rose(line) && baud_q != 13'h0000
        |-> low_q % {baud_q, 5'h00} == 20'h00000) else $error("low run not whole bit periods");
    AST_IRQ_MASK: assert property (irq_o |-> $past(mask_q) != 4'h0 && $past(ctrl_q[7:4]) != 4'h0)
        else $error("irq without enable");
endmodule
bind serial_cfg_top serial_cfg_checker #(.DIV_W(DIV_W)) chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o));

/* File: tb/tb_top.sv */
// self-checking bench for the serial configuration block
`timescale 1ns/1ps
`include "serial_cfg_map.vh"
module tb_top;
    reg         clk_i = 1'b0;
    reg         rst_b_i = 1'b0;
    reg  [3:0]  addr_i = 4'h0;
    reg  [15:0] wdata_i = 16'h0000;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    wire [15:0] rdata_o;
    wire        rxd_i;
    wire        txd_o;
    wire        txd_oe_o;
    wire        irq_o;
    wire        line = txd_oe_o ? txd_o : 1'b1;
    integer     error_cnt = 0;
    integer     tests_run = 0;
    integer     n;
    reg  [15:0] rv;
    always #2.5 clk_i = ~clk_i;
    serial_cfg_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o));
    remote_serial_peer peer (.clk_i(clk_i), .rxd_o(rxd_i));
    ////////////////////////////////////////////////////////////
    task finish_test;
        begin
            $display("checks %0d errors %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp, input string m);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            addr_i  <= a;
            wdata_i <= d;
            wr_i    <= 1'b1;
            @(posedge clk_i);
            wr_i    <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i   <= 1'b1;
            @(posedge clk_i);
            rd_i   <= 1'b0;
            @(negedge clk_i);
            rv = rdata_o;
        end
    endtask
    // bounded wait for irq high or line low; running out ends the run
    task wait_until(input sel, input integer lim);
        begin
            for (n = 0; ((sel ? irq_o : !line) !== 1'b1) && n < lim; n = n + 1)
                @(negedge clk_i);
            if (n >= lim) begin
                error_cnt = error_cnt + 1;
                $display("FAIL %0t wait ran out", $time);
                finish_test;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////
    task reg_check;
        begin
            rd(`ADDR_CTRL);
            chk(rv, `CTRL_RESET, "ctrl reset");
            wr(`ADDR_CTRL, 16'hFFFE);
            rd(`ADDR_CTRL);
            chk(rv & 16'hFFFD, 16'h7FFC, "ctrl write");
            wr(`ADDR_CTRL, 16'h0000);
            wr(4'hF, 16'hFFFF);
            rd(4'hF);
            chk(rv, 16'h0000, "unmapped");
            wr(`ADDR_BAUD, 16'h1FFF);
            rd(`ADDR_BAUD);
            chk(rv[12:0], 16'h1FFF, "baud max");
            $display("registers done");
        end
    endtask
    // sample mid-bit; a wrong period drifts samples into the wrong bits
    task tx_frame(input [7:0] d, input [15:0] mode, input integer div);
        reg [9:0] f;
        integer   i;
        begin
            f = {1'b1, d, 1'b0};
            if (mode[`BIT_PAR_ON])
                f[8] = ^d[6:0] ^ mode[`BIT_PAR_ODD];
            wr(`ADDR_BAUD, div[15:0]);
            wr(`ADDR_CTRL, mode | 16'h0008); // changed only between frames
            wr(`ADDR_TXDATA, {8'h00, d});
            wait_until(1'b0, 200 * div);
            repeat (16 * div) @(negedge clk_i);
            for (i = 0; i < 10; i = i + 1) begin
                chk(line, f[i], "tx bit");
                if (mode[`BIT_OPEN_DRAIN])
                    chk(txd_oe_o, !f[i], "open drain");
                repeat (32 * div) @(negedge clk_i);
            end
            $display("tx %h mode %h done", d, mode);
        end
    endtask
    task irq_step(input [3:0] a, input [15:0] d, input exp);
        begin
            wr(a, d);
            repeat (2) @(negedge clk_i);
            chk(irq_o, exp, "irq level");
        end
    endtask
    task loop_irq;
        begin
            wr(`ADDR_IRQ_MASK, 16'h0004);
            wr(`ADDR_CTRL, 16'h442C);
            wr(`ADDR_TXDATA, 16'h003C);
            wait_until(1'b1, 800);
            rd(`ADDR_RXDATA);
            chk(rv[7:0], 16'h003C, "loopback");
            rd(`ADDR_STATUS);
            chk(rv[4], 16'h0000, "rx parity");
            irq_step(`ADDR_IRQ_MASK, 16'h0000, 1'b0);
            irq_step(`ADDR_IRQ_MASK, 16'h0004, 1'b1);
            irq_step(`ADDR_IRQ_STAT, 16'h0004, 1'b0);
            $display("loopback and irq done");
        end
    endtask
    task rx_check;
        begin
            wr(`ADDR_CTRL, 16'h0034);
            wr(`ADDR_IRQ_STAT, 16'h000F);
            peer.send(8'hC3, 1);
            wait_until(1'b1, 100);
            rd(`ADDR_RXDATA);
            chk(rv[7:0], 16'h00C3, "rx data");
            rd(`ADDR_IRQ_STAT);
            chk(rv[2], 16'h0001, "rx full flag");
            // clear the receive event of this frame so only a new idle can set a flag here
            wr(`ADDR_IRQ_STAT, 16'h000F);
            repeat (700) @(negedge clk_i);
            rd(`ADDR_IRQ_STAT);
            chk(rv[3:2], 16'h0002, "idle after frame");
            $display("receive done");
        end
    endtask
    // break holds the line low while set, released at the next bit tick
    task break_check;
        begin
            wr(`ADDR_CTRL, 16'h0009);
            repeat (70) @(negedge clk_i);
            chk(line, 1'b0, "break low");
            wr(`ADDR_CTRL, 16'h0008);
            repeat (70) @(negedge clk_i);
            chk(line, 1'b1, "break released");
            $display("break done");
        end
    endtask
    // divisor zero: a queued byte must never leave
    task stop_check;
        integer lows;
        begin
            lows = 0;
            wr(`ADDR_BAUD, 16'h0000);
            wr(`ADDR_CTRL, 16'h0008);
            wr(`ADDR_TXDATA, 16'h0000);
            repeat (400) begin
                @(negedge clk_i);
                lows = lows + (line ? 0 : 1);
            end
            chk(lows[15:0], 16'h0000, "stopped line");
            $display("stop done");
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        reg_check;
        tx_frame(8'hA5, 16'h0000, 1);
        tx_frame(8'h5A, 16'h0000, 3);
        tx_frame(8'h96, 16'h0400, 1);
        tx_frame(8'h96, 16'h0C00, 2);
        tx_frame(8'h3B, 16'h2000, 1);
        loop_irq;
        rx_check;
        break_check;
        stop_check;
        finish_test;
    end
endmodule
